// file: bench/aswp_axi_master_model.sv
`timescale 1ns/100ps
module aswp_axi_master_model (
    input wire logic i_clk_sys,
    output logic [31:0] o_awaddr,
    output logic [3:0] o_awid,
    output logic [7:0] o_awlen,
    output logic [2:0] o_awsize,
    output logic [1:0] o_awburst,
    output logic [2:0] o_awprot,
    output logic [19:0] o_awuser,
    output logic o_awvalid,
    output logic [31:0] o_wdata,
    output logic [3:0] o_wstrb,
    output logic o_wvalid,
    output logic o_bready,
    input wire logic i_awready,
    input wire logic i_wready,
    input wire logic [3:0] i_bid,
    input wire logic [1:0] i_bresp,
    input wire logic i_bvalid
);
    initial begin
        {o_awaddr, o_awid, o_awlen, o_awsize, o_awburst, o_awprot, o_awuser} = '0;
        {o_awvalid, o_wdata, o_wstrb, o_wvalid, o_bready} = '0;
    end
    // Ready judged just after the falling edge; the next rising edge moves it
    task automatic hold(input logic aw);
        #1;
        while (!(aw ? i_awready : i_wready)) begin
            @(negedge i_clk_sys);
            #1;
        end
        @(negedge i_clk_sys);
    endtask
    task automatic burst(input logic [71:0] f, input logic [31:0] d0, output logic [5:0] b);
        @(negedge i_clk_sys);
        {o_awaddr, o_awid, o_awlen, o_awsize, o_awburst, o_awprot, o_awuser} = f;
        o_awvalid = 1'b1;
        hold(1'b1);
        o_awvalid = 1'b0;
        o_awaddr = ~o_awaddr;
        o_awuser = ~o_awuser;
        o_wvalid = 1'b1;
        for (int k = 0; k <= int'(f[35:28]); k++) begin
            o_wdata = d0 + 32'(k);
            o_wstrb = o_wdata[3:0];
            hold(1'b0);
        end
        o_wvalid = 1'b0;
        o_wdata = ~o_wdata;
        repeat ($urandom_range(2)) @(negedge i_clk_sys);
        o_bready = 1'b1;
        #1;
        while (!i_bvalid) begin
            @(negedge i_clk_sys);
            #1;
        end
        b = {i_bid, i_bresp};
        @(negedge i_clk_sys);
        o_bready = 1'b0;
    endtask
endmodule // aswp_axi_master_model

// file: bench/aswp_write_port_props.sv
`timescale 1ns/100ps
module aswp_write_port_props #(
    parameter int ADDR_W = 32,
    parameter int ID_W = 4,
    parameter int DEV_W = 16,
    parameter int USER_W = 20,
    parameter logic [ADDR_W-1:0] XLATE_ADDR = '0
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic [ADDR_W-1:0] i_awaddr,
    input wire logic [2:0] i_awsize,
    input wire logic [USER_W-1:0] i_awuser,
    input wire logic i_awvalid,
    input wire logic o_awready,
    input wire logic [ID_W-1:0] o_bid,
    input wire logic [1:0] o_bresp,
    input wire logic o_bvalid,
    input wire logic i_bready,
    input wire logic o_wr_valid,
    input wire logic i_wr_ready,
    input wire logic [ADDR_W-1:0] o_wr_addr,
    input wire logic [2:0] o_wr_core,
    input wire logic o_wr_xlate,
    input wire logic [DEV_W-1:0] o_wr_devnum
);
    logic [ADDR_W-1:0] cap_addr;
    logic [USER_W-1:0] cap_user;
    logic bad_size;
    // Burst fields kept, since beats come out long after the address phase
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cap_addr <= '0;
            cap_user <= '0;
            bad_size <= 1'b0;
        end else if (i_awvalid && o_awready) begin
            cap_addr <= i_awaddr;
            cap_user <= i_awuser;
            bad_size <= i_awsize > aswp_pkg::MAX_SIZE;
        end
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    sequence aw_take; i_awvalid && o_awready; endsequence
    sequence b_take; o_bvalid && i_bready; endsequence
    a_aw_closes: assert property (aw_take |=> !o_awready)
        else $error("address taken while a burst is open");
    a_beat_holds: assert property (o_wr_valid && !i_wr_ready |=>
        o_wr_valid && $stable(o_wr_addr))
        else $error("stalled beat changed");
    a_resp_holds: assert property (o_bvalid && !i_bready |=>
        o_bvalid && $stable({o_bid, o_bresp}))
        else $error("stalled response changed");
    a_b_reopens: assert property (b_take |=> o_awready)
        else $error("address channel not reopened");
    a_core_index: assert property (o_wr_valid |-> o_wr_core == cap_user[2:0])
        else $error("core index wrong");
    a_xlate_addr: assert property (o_wr_valid && cap_user[3] |-> o_wr_xlate
        && o_wr_devnum == cap_addr[DEV_W+1:2] && o_wr_addr == XLATE_ADDR)
        else $error("flagged write decoded wrong");
    a_user_dev: assert property (o_wr_valid && !cap_user[3] && cap_addr == XLATE_ADDR
        |-> o_wr_xlate && o_wr_devnum == cap_user[DEV_W+3:4])
        else $error("register write decoded wrong");
    a_resp_code: assert property (o_bvalid |-> !o_wr_valid && o_bresp ==
        (bad_size ? aswp_pkg::RESP_SLVERR : aswp_pkg::RESP_OKAY))
        else $error("response code wrong");
endmodule // aswp_write_port_props

bind aswp_write_port aswp_write_port_props #(.ADDR_W(ADDR_W), .ID_W(ID_W), .DEV_W(DEV_W),
    .USER_W(USER_W), .XLATE_ADDR(XLATE_ADDR)) u_props (.*);

// file: bench/test_axi_slave_write_port.sv
`timescale 1ns/100ps
module test_axi_slave_write_port;
    localparam logic [31:0] XA = aswp_pkg::DEF_XLATE_ADDR;
    logic i_clk_sys = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_wr_ready = 1'b0;
    logic [31:0] i_awaddr, i_wdata, o_wr_addr, o_wr_data;
    logic [3:0] i_awid, i_wstrb, o_bid, o_wr_strb;
    logic [7:0] i_awlen;
    logic [2:0] i_awsize, i_awprot, o_wr_prot, o_wr_core;
    logic [1:0] i_awburst, o_bresp;
    logic [19:0] i_awuser;
    logic [15:0] o_wr_devnum;
    logic i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid, i_bready, o_wr_valid, o_wr_xlate;
    logic [90:0] exp_q[$];
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;
    always #4 i_clk_sys = ~i_clk_sys;
    aswp_write_port dut (.*);
    aswp_axi_master_model partner (.i_clk_sys, .o_awaddr(i_awaddr), .o_awid(i_awid),
        .o_awlen(i_awlen), .o_awsize(i_awsize), .o_awburst(i_awburst), .o_awprot(i_awprot),
        .o_awuser(i_awuser), .o_awvalid(i_awvalid), .o_wdata(i_wdata), .o_wstrb(i_wstrb),
        .o_wvalid(i_wvalid), .o_bready(i_bready), .i_awready(o_awready), .i_wready(o_wready),
        .i_bid(o_bid), .i_bresp(o_bresp), .i_bvalid(o_bvalid));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [90:0] got, input logic [90:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] beat_addr(logic [71:0] f, int k);
        logic [31:0] a, tot, base;
        a = f[71:40];
        tot = (32'(f[35:28]) + 32'h1) << f[27:25];
        base = a & ~(tot - 32'h1);
        if (f[3]) return XA;
        if (f[24:23] == aswp_pkg::BURST_FIXED) return a;
        if (f[24:23] == aswp_pkg::BURST_WRAP) begin
            return base + ((a - base + (32'(k) << f[27:25])) % tot);
        end
        return a + (32'(k) << f[27:25]);
    endfunction
    function automatic logic [16:0] dev_of(logic [71:0] f);
        if (f[3]) return {1'b1, f[57:42]};
        if (f[71:40] == XA) return {1'b1, f[19:4]};
        return 17'h0;
    endfunction
    task automatic run(input logic [71:0] f, input logic [31:0] d0);
        logic [5:0] b;
        logic [31:0] d;
        if (f[27:25] <= aswp_pkg::MAX_SIZE) begin
            for (int k = 0; k <= int'(f[35:28]); k++) begin
                d = d0 + 32'(k);
                exp_q.push_back({beat_addr(f, k), d, d[3:0], f[22:20], f[2:0], dev_of(f)});
            end
        end
        partner.burst(f, d0, b);
        chk(91'(b), 91'({f[39:36], f[27:25] > aswp_pkg::MAX_SIZE ? 2'h2 : 2'h0}));
        $display("burst done len %0d size %0d", f[35:28], f[27:25]);
    endtask
    // Sink stalls at random so beats and responses wait on the drain
    always @(negedge i_clk_sys) begin
        i_wr_ready = ($urandom_range(3) != 0);
        #1;
        if (o_wr_valid === 1'b1 && i_wr_ready) begin
            chk({o_wr_addr, o_wr_data, o_wr_strb, o_wr_prot, o_wr_core, o_wr_xlate,
                o_wr_devnum}, exp_q.pop_front());
        end
    end
    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 6000) begin
            failures++;
            report_and_stop();
        end
    end
    initial begin
        logic [71:0] f;
        void'($urandom(54104));
        repeat (10) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        i_rst_b = 1'b1;
        #1;
        chk(91'({o_awready, o_wready, o_bvalid, o_wr_valid}), 91'h8);
        run({32'h2468, 4'h3, 8'h0, 3'h2, 2'h1, 3'h5, 16'hBEEF, 1'b1, 3'h6}, 32'hA5A5_0001);
        run({XA, 4'hC, 8'h0, 3'h2, 2'h1, 3'h2, 16'h1357, 1'b0, 3'h1}, 32'h5A5A_0010);
        run({32'h100, 4'h9, 8'h2, 3'h3, 2'h1, 3'h0, 20'h4}, 32'h0);
        run({32'h218, 4'h7, 8'h3, 3'h2, 2'h2, 3'h1, 20'h3}, 32'h1000_0000);
        for (int n = 0; n < 40; n++) begin
            f = {$urandom & ~32'h3, 4'($urandom), 8'($urandom_range(3)),
                3'($urandom_range(2)), 2'($urandom_range(3)), 3'($urandom), 20'($urandom)};
            if (f[24:23] == aswp_pkg::BURST_WRAP) f[28] = 1'b1;
            run(f, $urandom);
        end
        repeat (4) @(negedge i_clk_sys);
        chk(91'(exp_q.size()), 91'h0);
        report_and_stop();
    end
endmodule // test_axi_slave_write_port

// file: src/aswp_decode.sv
`timescale 1ns/100ps
module aswp_decode #(
    parameter int ADDR_W = 32,
    parameter int DEV_W = 16,
    parameter logic [ADDR_W-1:0] XLATE_ADDR = aswp_pkg::DEF_XLATE_ADDR[ADDR_W-1:0]
) (
    aswp_decode_if.decoder dec
);
    // ----------------------------------------
    // Sideband decode
    // ----------------------------------------
    logic user_xlate;
    logic addr_hit;

    assign dec.core = dec.user[aswp_pkg::USER_CORE_LSB +: aswp_pkg::CORE_W];
    assign user_xlate = dec.user[aswp_pkg::USER_XLATE_BIT];
    assign addr_hit = (dec.addr == XLATE_ADDR);
    assign dec.xlate = user_xlate || addr_hit;
    // Flagged write goes to XLATE_ADDR; its own address gives the devnum
    assign dec.eff_addr = user_xlate ? XLATE_ADDR : dec.addr;

    always_comb begin
        if (user_xlate) begin
            dec.devnum = dec.addr[aswp_pkg::ADDR_DEV_LSB +: DEV_W];
        end else if (addr_hit) begin
            dec.devnum = dec.user[aswp_pkg::USER_DEV_LSB +: DEV_W];
        end else begin
            dec.devnum = '0;
        end
    end
endmodule // aswp_decode

// file: src/aswp_decode_if.sv
`timescale 1ns/100ps
interface aswp_decode_if #(
    parameter int ADDR_W = 32,
    parameter int USER_W = 20,
    parameter int DEV_W = 16
);
    logic [ADDR_W-1:0] addr;
    logic [USER_W-1:0] user;
    logic xlate;
    logic [aswp_pkg::CORE_W-1:0] core;
    logic [DEV_W-1:0] devnum;
    logic [ADDR_W-1:0] eff_addr;

    modport port (output addr, output user, input xlate, input core, input devnum,
                  input eff_addr);
    modport decoder (input addr, input user, output xlate, output core, output devnum,
                     output eff_addr);
endinterface

// file: src/aswp_pkg.sv
package aswp_pkg;
    // ----------------------------------------
    // Widths of the slave port
    // ----------------------------------------
    localparam int DATA_W = 32;
    localparam int STRB_W = DATA_W / 8;
    localparam int LEN_W = 8;
    localparam int SIZE_W = 3;
    localparam int BURST_W = 2;
    localparam int PROT_W = 3;
    localparam int RESP_W = 2;
    localparam int CORE_W = 3;
    // ----------------------------------------
    // Sideband field positions
    // ----------------------------------------
    localparam int USER_CORE_LSB = 0;
    localparam int USER_XLATE_BIT = 3;
    localparam int USER_DEV_LSB = 4;
    localparam int ADDR_DEV_LSB = 2;
    // ----------------------------------------
    // Defaults and encodings
    // ----------------------------------------
    localparam int DEF_ADDR_W = 32;
    localparam int DEF_ID_W = 4;
    localparam int DEF_DEV_W = 16;
    localparam logic [31:0] DEF_XLATE_ADDR = 32'h0001_0040;
    localparam logic [SIZE_W-1:0] MAX_SIZE = 3'h2;
    localparam logic [BURST_W-1:0] BURST_FIXED = 2'h0;
    localparam logic [BURST_W-1:0] BURST_WRAP = 2'h2;
    localparam logic [RESP_W-1:0] RESP_OKAY = 2'h0;
    localparam logic [RESP_W-1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ASWP_ST_ADDR = 2'b00,
        ASWP_ST_DATA = 2'b01,
        ASWP_ST_RESP = 2'b10
    } aswp_state_t;
endpackage

// file: src/aswp_write_port.sv
`timescale 1ns/100ps
module aswp_write_port #(
    parameter int ADDR_W = aswp_pkg::DEF_ADDR_W,
    parameter int ID_W = aswp_pkg::DEF_ID_W,
    parameter int DEV_W = aswp_pkg::DEF_DEV_W,
    parameter int USER_W = DEV_W + aswp_pkg::USER_DEV_LSB,
    parameter logic [ADDR_W-1:0] XLATE_ADDR = aswp_pkg::DEF_XLATE_ADDR[ADDR_W-1:0]
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic [ADDR_W-1:0] i_awaddr,
    input wire logic [ID_W-1:0] i_awid,
    input wire logic [aswp_pkg::LEN_W-1:0] i_awlen,
    input wire logic [aswp_pkg::SIZE_W-1:0] i_awsize,
    input wire logic [aswp_pkg::BURST_W-1:0] i_awburst,
    input wire logic [aswp_pkg::PROT_W-1:0] i_awprot,
    input wire logic [USER_W-1:0] i_awuser,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [aswp_pkg::DATA_W-1:0] i_wdata,
    input wire logic [aswp_pkg::STRB_W-1:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [ID_W-1:0] o_bid,
    output logic [aswp_pkg::RESP_W-1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    output logic o_wr_valid,
    input wire logic i_wr_ready,
    output logic [ADDR_W-1:0] o_wr_addr,
    output logic [aswp_pkg::DATA_W-1:0] o_wr_data,
    output logic [aswp_pkg::STRB_W-1:0] o_wr_strb,
    output logic [aswp_pkg::PROT_W-1:0] o_wr_prot,
    output logic [aswp_pkg::CORE_W-1:0] o_wr_core,
    output logic o_wr_xlate,
    output logic [DEV_W-1:0] o_wr_devnum
);
    // ----------------------------------------
    // Burst address step
    // ----------------------------------------
    function automatic logic [ADDR_W-1:0] step_addr(
        input logic [ADDR_W-1:0] addr,
        input logic [aswp_pkg::SIZE_W-1:0] size,
        input logic [aswp_pkg::LEN_W-1:0] len,
        input logic [aswp_pkg::BURST_W-1:0] burst
    );
        logic [ADDR_W-1:0] incr;
        logic [ADDR_W-1:0] span;
        logic [ADDR_W-1:0] sum;
        incr = ADDR_W'(1) << size;
        span = (ADDR_W'(len) + ADDR_W'(1)) << size;
        sum = addr + incr;
        if (burst == aswp_pkg::BURST_FIXED) begin
            step_addr = addr;
        end else if (burst == aswp_pkg::BURST_WRAP) begin
            step_addr = (addr & ~(span - ADDR_W'(1))) | (sum & (span - ADDR_W'(1)));
        end else begin
            step_addr = sum;
        end
    endfunction

    // ----------------------------------------
    // Sideband decoder
    // ----------------------------------------
    aswp_decode_if #(.ADDR_W(ADDR_W), .USER_W(USER_W), .DEV_W(DEV_W)) dec_bus ();

    aswp_decode #(
        .ADDR_W(ADDR_W),
        .DEV_W(DEV_W),
        .XLATE_ADDR(XLATE_ADDR)
    ) u_decode (
        .dec(dec_bus.decoder)
    );

    assign dec_bus.addr = i_awaddr;
    assign dec_bus.user = i_awuser;

    // ----------------------------------------
    // Burst state
    // ----------------------------------------
    aswp_pkg::aswp_state_t state;
    logic [ADDR_W-1:0] beat_addr;
    logic [aswp_pkg::LEN_W-1:0] beats_left;
    logic [aswp_pkg::LEN_W-1:0] burst_len;
    logic [aswp_pkg::SIZE_W-1:0] burst_size;
    logic [aswp_pkg::BURST_W-1:0] burst_kind;
    logic [aswp_pkg::PROT_W-1:0] burst_prot;
    logic [aswp_pkg::CORE_W-1:0] burst_core;
    logic burst_xlate;
    logic [DEV_W-1:0] burst_devnum;
    logic burst_bad;
    logic burst_pinned;
    logic aw_fire;
    logic w_fire;
    logic b_fire;

    // No last-beat flag on the bus, so awlen alone ends the burst
    assign o_awready = (state == aswp_pkg::ASWP_ST_ADDR);
    // Stage may refill in the cycle it drains
    assign o_wready = (state == aswp_pkg::ASWP_ST_DATA) && (!o_wr_valid || i_wr_ready);
    // Response waits for the last write to leave the stage
    assign o_bvalid = (state == aswp_pkg::ASWP_ST_RESP) && !o_wr_valid;
    assign aw_fire = i_awvalid && o_awready;
    assign w_fire = i_wvalid && o_wready;
    assign b_fire = o_bvalid && i_bready;

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state <= aswp_pkg::ASWP_ST_ADDR;
            beats_left <= '0;
        end else begin
            case (state)
                aswp_pkg::ASWP_ST_ADDR: begin
                    if (aw_fire) begin
                        state <= aswp_pkg::ASWP_ST_DATA;
                        beats_left <= i_awlen;
                    end
                end
                aswp_pkg::ASWP_ST_DATA: begin
                    if (w_fire) begin
                        if (beats_left == '0) begin
                            state <= aswp_pkg::ASWP_ST_RESP;
                        end else begin
                            beats_left <= beats_left - aswp_pkg::LEN_W'(1);
                        end
                    end
                end
                aswp_pkg::ASWP_ST_RESP: begin
                    if (b_fire) begin
                        state <= aswp_pkg::ASWP_ST_ADDR;
                    end
                end
                default: begin
                    state <= aswp_pkg::ASWP_ST_ADDR;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Captured address phase
    // ----------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            beat_addr <= '0;
            burst_len <= '0;
            burst_size <= '0;
            burst_kind <= '0;
            burst_prot <= '0;
            burst_core <= '0;
            burst_xlate <= 1'b0;
            burst_devnum <= '0;
            burst_bad <= 1'b0;
            burst_pinned <= 1'b0;
            o_bid <= '0;
        end else if (aw_fire) begin
            beat_addr <= dec_bus.eff_addr;
            burst_len <= i_awlen;
            burst_size <= i_awsize;
            burst_kind <= i_awburst;
            burst_prot <= i_awprot;
            burst_core <= dec_bus.core;
            burst_xlate <= dec_bus.xlate;
            burst_devnum <= dec_bus.devnum;
            // Beats wider than the data path cannot be honoured
            burst_bad <= (i_awsize > aswp_pkg::MAX_SIZE);
            o_bid <= i_awid;
            // Flagged bursts land every beat on the translation register
            burst_pinned <= i_awuser[aswp_pkg::USER_XLATE_BIT];
        end else if (w_fire && !burst_pinned) begin
            beat_addr <= step_addr(beat_addr, burst_size, burst_len, burst_kind);
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_bresp <= aswp_pkg::RESP_OKAY;
        end else if (aw_fire) begin
            o_bresp <= (i_awsize > aswp_pkg::MAX_SIZE) ? aswp_pkg::RESP_SLVERR
                                                        : aswp_pkg::RESP_OKAY;
        end
    end

    // ----------------------------------------
    // Internal write stage
    // ----------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_wr_valid <= 1'b0;
        end else if (w_fire) begin
            // Bad-size beats are taken and dropped
            o_wr_valid <= !burst_bad;
        end else if (i_wr_ready) begin
            o_wr_valid <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_wr_addr <= '0;
            o_wr_data <= '0;
            o_wr_strb <= '0;
            o_wr_prot <= '0;
            o_wr_core <= '0;
            o_wr_xlate <= 1'b0;
            o_wr_devnum <= '0;
        end else if (w_fire) begin
            o_wr_addr <= beat_addr;
            o_wr_data <= i_wdata;
            o_wr_strb <= i_wstrb;
            o_wr_prot <= burst_prot;
            o_wr_core <= burst_core;
            o_wr_xlate <= burst_xlate;
            o_wr_devnum <= burst_devnum;
        end
    end
endmodule // aswp_write_port
